// file: inc/bsc_pkg.sv
// What this block does
// [RL1] set the changeover flag whenever supply moves from main to backup
// [RL2] flag readable by host only while running from main supply
// [RL3] an interrupt pulse can also fire on return to main supply
// [RL4] on backup: clock and timestamp outputs high-z, bus and digital timestamp input ignored
// [RL5] on backup: switch detector stays on, first irq pin keeps irq/indicator, drops clock
// [RL6] bit 4 low enables changeover, high disables it; default enabled
// [RL7] bit 3 picks refresh rate, low by default
// [RL8] bits 2..1 pick compare reference: threshold, backup, higher, lower
// [RL9] main supply chosen when above reference, backup otherwise, automatically
// [RL10] bit 0 picks threshold: 0 low level default, 1 high level
// [RL11] two enable bits route the changeover event to each irq pin
// [RL12] enabled irq is either a pulse or a level following the flag
// [RL13] flag stays set until host clears it by a register write
// [RL14] pulse on every changeover in either direction even if flag still set
// [RL15] indicator mode: first irq pin shows only present supply selection
// [RL16] second irq pin drives only while on main supply
// [RL17] pulse starts with event, ends on slow tick, one to two ticks long; a host flag clear on main supply also ends it early here
// [RL18] level mode holds pin until all enabled routed flags are cleared
// [RL19] upper three config bits read zero and ignore writes
package bsc_pkg;
  localparam logic [7:0] BSC_CFG_ADDR = 8'h26;
  localparam logic [7:0] BSC_CFG_RESET = 8'h00;
  localparam logic [7:0] BSC_CFG_WMASK = 8'h1f;
  localparam int BSC_OFF_BIT = 4;
  localparam int BSC_RR_BIT = 3;
  localparam int BSC_MODE_HI = 2;
  localparam int BSC_MODE_LO = 1;
  localparam int BSC_TH_BIT = 0;
  localparam logic [1:0] BSC_PM_CLOCK = 2'h0;
  localparam logic [1:0] BSC_PM_BATIND = 2'h1;
  localparam logic [1:0] BSC_PM_IRQ = 2'h2;
  localparam logic [1:0] BSC_PM_HIZ = 2'h3;
  localparam logic [1:0] BSC_CMP_TH = 2'h0;
  localparam logic [1:0] BSC_CMP_BAT = 2'h1;
  localparam logic [1:0] BSC_CMP_HIGH = 2'h2;
  localparam logic [1:0] BSC_CMP_LOW = 2'h3;
  localparam longint BSC_CLK_HZ = 200000000;
  localparam longint BSC_TICK_HZ = 128;
  localparam int BSC_TICK_CYCLES = int'(BSC_CLK_HZ / BSC_TICK_HZ);
endpackage : bsc_pkg

// file: src/bsc_battery_switchover.sv
`timescale 1ns/10ps
module bsc_battery_switchover #(
  parameter int TICK_CYCLES = bsc_pkg::BSC_TICK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic flag_clear_in,
  input wire logic above_th_in,
  input wire logic above_bat_in,
  input wire logic irq_en_first_in,
  input wire logic irq_en_second_in,
  input wire logic irq_pulse_mode_in,
  input wire logic [1:0] first_irq_pin_mode_in,
  input wire logic clk_out_sel_in,
  input wire logic ts_out_en_in,
  input wire logic ts_out_in,
  input wire logic ts_din_in,
  input wire logic bus_scl_in,
  input wire logic bus_sda_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic supply_changeover_flag_out,
  output logic flag_valid_out,
  output logic on_backup_out,
  output logic changeover_refresh_rate_out,
  output logic changeover_threshold_select_out,
  output logic [1:0] changeover_compare_mode_out,
  output logic first_irq_pin_oe_out,
  output logic second_irq_pin_oe_out,
  output logic second_irq_pin_out,
  output logic clk_pin_oe_out,
  output logic ts_pin_oe_out,
  output logic ts_pin_out,
  output logic ts_din_out,
  output logic bus_scl_out,
  output logic bus_sda_out,
  output logic ts_mech_en_out
);
  logic [4:0] cfg_r;
  logic backup_r;
  logic flag_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic pulse_a_r;
  logic pulse_b_r;
  logic pulse_a_arm_r;
  logic pulse_b_arm_r;

  // comparison reference per mode; main wins when above it
  wire cmp_hi = above_th_in & above_bat_in;
  wire cmp_lo = above_th_in | above_bat_in;
  wire [1:0] mode = cfg_r[bsc_pkg::BSC_MODE_HI:bsc_pkg::BSC_MODE_LO]; // [RL8]
  wire main_ok = (mode == bsc_pkg::BSC_CMP_TH) ? above_th_in :
                 (mode == bsc_pkg::BSC_CMP_BAT) ? above_bat_in :
                 (mode == bsc_pkg::BSC_CMP_HIGH) ? cmp_hi : cmp_lo; // [RL9]
  // disabled feature: supplies are tied together, so stay on main
  wire backup_nxt = ~cfg_r[bsc_pkg::BSC_OFF_BIT] & ~main_ok; // [RL6]
  wire to_backup = backup_nxt & ~backup_r;
  wire to_main = ~backup_nxt & backup_r;
  wire change = to_backup | to_main;
  // bus is dead on backup, so writes and reads are ignored then
  wire bus_live = ~backup_r; // [RL4]
  wire cfg_hit = bus_live & (reg_addr_in == bsc_pkg::BSC_CFG_ADDR);
  wire cfg_wr = reg_wr_in & cfg_hit;
  wire flag_clr = flag_clear_in & bus_live; // [RL13]
  wire tick_last = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // configuration register; upper bits never stored
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_r <= bsc_pkg::BSC_CFG_RESET[4:0];
    end else if (cfg_wr) begin
      cfg_r <= reg_wdata_in[4:0] & bsc_pkg::BSC_CFG_WMASK[4:0]; // [RL19] [RL7] [RL10]
    end
  end

  // supply selection follows comparators with no software action
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      backup_r <= 1'b0;
    end else begin
      backup_r <= backup_nxt; // [RL9]
    end
  end

  // sticky flag; a new switch to backup wins over a same-cycle clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_r <= 1'b0;
    end else if (to_backup) begin
      flag_r <= 1'b1; // [RL1]
    end else if (flag_clr) begin
      flag_r <= 1'b0; // [RL13]
    end
  end

  // free-running slow tick; asynchronous to events, hence 1..2 periods
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_last ? 32'h0 : tick_cnt_r + 32'h1;
      tick_r <= tick_last;
    end
  end

  // pulse generators: start on any changeover, end on second tick after or on a flag clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pulse_a_r <= 1'b0;
      pulse_a_arm_r <= 1'b0;
    end else if (change & irq_en_first_in) begin
      pulse_a_r <= 1'b1; // [RL3] [RL14]
      pulse_a_arm_r <= 1'b0;
    end else if (flag_clr | (tick_r & pulse_a_arm_r)) begin
      pulse_a_r <= 1'b0; // [RL17]
      pulse_a_arm_r <= 1'b0;
    end else if (tick_r & pulse_a_r) begin
      pulse_a_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pulse_b_r <= 1'b0;
      pulse_b_arm_r <= 1'b0;
    end else if (change & irq_en_second_in) begin
      pulse_b_r <= 1'b1; // [RL11] [RL14]
      pulse_b_arm_r <= 1'b0;
    end else if (flag_clr | (tick_r & pulse_b_arm_r)) begin
      pulse_b_r <= 1'b0; // [RL17]
      pulse_b_arm_r <= 1'b0;
    end else if (tick_r & pulse_b_r) begin
      pulse_b_arm_r <= 1'b1;
    end
  end

  // irq sources per pin, level follows flag or pulse generator
  wire irq_a = irq_pulse_mode_in ? pulse_a_r : (flag_r & irq_en_first_in); // [RL12] [RL18]
  wire irq_b = irq_pulse_mode_in ? pulse_b_r : (flag_r & irq_en_second_in); // [RL12] [RL18]
  // open-drain, active low: enabling the driver pulls the pin low
  wire pin_a_nxt = (first_irq_pin_mode_in == bsc_pkg::BSC_PM_BATIND) ? backup_nxt : // [RL15]
                   (first_irq_pin_mode_in == bsc_pkg::BSC_PM_IRQ) ? irq_a :
                   (first_irq_pin_mode_in == bsc_pkg::BSC_PM_CLOCK) ?
                   (clk_out_sel_in & ~backup_nxt) : 1'b0; // [RL5]
  wire [7:0] rd_word = {3'h0, cfg_r}; // [RL19]

  // read data, zero for unmapped addresses so a stray read shows nothing stale
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= (reg_rd_in & cfg_hit) ? rd_word : 8'h00;
    end
  end

  // read answer one cycle after the strobe, none while the bus is dead
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in & bus_live; // [RL4]
    end
  end

  // host view of the flag; forced low on backup since it cannot be read then
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      supply_changeover_flag_out <= 1'b0;
    end else begin
      supply_changeover_flag_out <= flag_r & ~backup_nxt; // [RL2]
    end
  end

  // tells the flag reader whether the visible value means anything
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_valid_out <= 1'b1;
    end else begin
      flag_valid_out <= ~backup_nxt; // [RL2]
    end
  end

  // present supply selection
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      on_backup_out <= 1'b0;
    end else begin
      on_backup_out <= backup_nxt; // [RL9]
    end
  end

  // refresh rate to the analog switch; no logic here depends on it
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      changeover_refresh_rate_out <= 1'b0;
    end else begin
      changeover_refresh_rate_out <= cfg_r[bsc_pkg::BSC_RR_BIT]; // [RL7]
    end
  end

  // threshold level select to the comparator
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      changeover_threshold_select_out <= 1'b0;
    end else begin
      changeover_threshold_select_out <= cfg_r[bsc_pkg::BSC_TH_BIT]; // [RL10]
    end
  end

  // compare mode mirrored for the analog side
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      changeover_compare_mode_out <= 2'h0;
    end else begin
      changeover_compare_mode_out <= mode; // [RL8]
    end
  end

  // first irq pin driver; uses next selection so it moves with on_backup_out
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      first_irq_pin_oe_out <= 1'b0;
    end else begin
      first_irq_pin_oe_out <= pin_a_nxt; // [RL5] [RL15]
    end
  end

  // second irq pin has no supply on backup, so its driver is released
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      second_irq_pin_oe_out <= 1'b0;
    end else begin
      second_irq_pin_oe_out <= ~backup_nxt; // [RL16]
    end
  end

  // second irq level, active low
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      second_irq_pin_out <= 1'b1;
    end else begin
      second_irq_pin_out <= ~irq_b; // [RL11]
    end
  end

  // clock pin driver off on backup
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_pin_oe_out <= 1'b0;
    end else begin
      clk_pin_oe_out <= clk_out_sel_in & ~backup_nxt; // [RL4]
    end
  end

  // timestamp pin driver off on backup
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ts_pin_oe_out <= 1'b0;
    end else begin
      ts_pin_oe_out <= ts_out_en_in & ~backup_nxt; // [RL4]
    end
  end

  // timestamp pin data; harmless while the driver is off
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ts_pin_out <= 1'b0;
    end else begin
      ts_pin_out <= ts_out_in;
    end
  end

  // digital timestamp input may float on backup, so it is masked
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ts_din_out <= 1'b0;
    end else begin
      ts_din_out <= ts_din_in & ~backup_nxt; // [RL4]
    end
  end

  // bus clock held idle high on backup so no false start is seen
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_scl_out <= 1'b1;
    end else begin
      bus_scl_out <= bus_scl_in | backup_nxt; // [RL4]
    end
  end

  // bus data held idle high on backup
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_sda_out <= 1'b1;
    end else begin
      bus_sda_out <= bus_sda_in | backup_nxt; // [RL4]
    end
  end

  // switch detector runs on either supply
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ts_mech_en_out <= 1'b1;
    end else begin
      ts_mech_en_out <= 1'b1; // [RL5]
    end
  end
endmodule : bsc_battery_switchover

// file: verification/bsc_battery_switchover_chk.sv
`timescale 1ns/10ps
// passive watch on the switchover block ports
module bsc_battery_switchover_chk #(parameter int TICK_CYCLES = 10) (
  input wire logic clk_sys_in, sys_rst_in, reg_rd_in, reg_rvalid_out, on_backup_out,
  input wire logic supply_changeover_flag_out, flag_valid_out, flag_clear_in, clk_pin_oe_out,
  input wire logic ts_pin_oe_out, bus_scl_out, bus_sda_out, second_irq_pin_oe_out,
  input wire logic second_irq_pin_out, irq_en_second_in, irq_pulse_mode_in, first_irq_pin_oe_out,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [1:0] first_irq_pin_mode_in
);
  // a pulse ends within two slow ticks; small margin for the output stage
  localparam int LIM = 2 * TICK_CYCLES + 4;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  AST_RVALID: assert property (reg_rvalid_out |-> $past(reg_rd_in) && !on_backup_out)
    else $error("unexpected read answer");
  AST_RD_ZERO: assert property (reg_rvalid_out |-> reg_rdata_out[7:5] == 3'h0)
    else $error("upper bits not zero");
  AST_FLAG_HIDE: assert property (on_backup_out |-> !supply_changeover_flag_out &&
    !flag_valid_out) else $error("flag visible on backup");
  AST_PINS_OFF: assert property (on_backup_out |-> !clk_pin_oe_out && !ts_pin_oe_out &&
    bus_scl_out && bus_sda_out && !second_irq_pin_oe_out) else $error("pin active on backup");
  AST_INDICATOR: assert property (first_irq_pin_mode_in == bsc_pkg::BSC_PM_BATIND &&
    $stable(first_irq_pin_mode_in) && $stable(on_backup_out) |->
    first_irq_pin_oe_out == on_backup_out) else $error("indicator wrong");
  AST_FLAG_HOLD: assert property ($past(supply_changeover_flag_out) && !on_backup_out &&
    !$past(on_backup_out) && !$past(flag_clear_in) && !$past(flag_clear_in, 2) |->
    supply_changeover_flag_out) else $error("flag dropped by itself");
  AST_PULSE_END: assert property ($rose(first_irq_pin_oe_out) && irq_pulse_mode_in &&
    first_irq_pin_mode_in == bsc_pkg::BSC_PM_IRQ |-> ##[1:LIM] !first_irq_pin_oe_out)
    else $error("pulse too long");
  AST_LEVEL: assert property (!irq_pulse_mode_in && irq_en_second_in &&
    $stable({irq_pulse_mode_in, irq_en_second_in}) && supply_changeover_flag_out &&
    $past(supply_changeover_flag_out) |-> !second_irq_pin_out) else $error("level irq off");
  COV_BACKUP: cover property ($rose(on_backup_out));
  COV_READ: cover property (reg_rvalid_out);
  COV_PULSE: cover property ($fell(first_irq_pin_oe_out) && irq_pulse_mode_in);
endmodule : bsc_battery_switchover_chk

bind bsc_battery_switchover bsc_battery_switchover_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys_in, .sys_rst_in, .reg_rd_in, .reg_rvalid_out, .on_backup_out,
  .supply_changeover_flag_out, .flag_valid_out, .flag_clear_in, .clk_pin_oe_out,
  .ts_pin_oe_out, .bus_scl_out, .bus_sda_out, .second_irq_pin_oe_out, .second_irq_pin_out,
  .irq_en_second_in, .irq_pulse_mode_in, .first_irq_pin_oe_out, .reg_rdata_out,
  .first_irq_pin_mode_in);

// file: verification/bsc_host_model.sv
`timescale 1ns/10ps
// host side: strobes change at falling edges and last one cycle
module bsc_host_model (
  input wire logic clk_in, rvalid_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out = 1'h0, rd_out = 1'h0, clr_out = 1'h0,
  output logic [7:0] addr_out = 8'h00, wdata_out = 8'h00
);
  // single byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    {wr_out, addr_out, wdata_out} = {1'h1, a, v};
    @(negedge clk_in);
    wr_out = 1'h0;
  endtask : wr
  // data is taken while the one-cycle valid stands; unknown if it never comes
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    v = 8'hxx;
    @(negedge clk_in);
    {rd_out, addr_out} = {1'h1, a};
    @(negedge clk_in);
    rd_out = 1'h0;
    repeat (2) begin
      if (rvalid_in === 1'h1) v = rdata_in;
      @(negedge clk_in);
    end
  endtask : rd
  // the flag goes away only through this host write
  task automatic clear();
    @(negedge clk_in);
    clr_out = 1'h1;
    @(negedge clk_in);
    clr_out = 1'h0;
  endtask : clear
endmodule : bsc_host_model

// file: verification/tb_battery_switchover_control.sv
`timescale 1ns/10ps
module tb_battery_switchover_control;
  localparam int T = 10;
  logic clk_sys_in = 0, sys_rst_in = 1, above_th_in = 1, above_bat_in = 1, irq_en_first_in = 1;
  logic irq_en_second_in = 1, irq_pulse_mode_in = 0, clk_out_sel_in = 0, ts_out_en_in = 0;
  logic ts_out_in = 0, ts_din_in = 0, bus_scl_in = 0, bus_sda_in = 0, reg_wr_in, reg_rd_in;
  logic flag_clear_in, reg_rvalid_out, supply_changeover_flag_out, flag_valid_out, on_backup_out;
  logic changeover_refresh_rate_out, changeover_threshold_select_out, first_irq_pin_oe_out;
  logic second_irq_pin_oe_out, second_irq_pin_out, clk_pin_oe_out, ts_pin_oe_out, ts_pin_out;
  logic ts_din_out, bus_scl_out, bus_sda_out, ts_mech_en_out;
  logic [1:0] first_irq_pin_mode_in = 2'h2, changeover_compare_mode_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
  logic [31:0] seed = 32'hf028ffd3;
  int errors = 0, comparisons = 0, cyc = 0, n;
  bsc_battery_switchover #(.TICK_CYCLES(T)) u_dut (.*);
  bsc_host_model u_host (.clk_in(clk_sys_in), .rvalid_in(reg_rvalid_out), .rdata_in(reg_rdata_out),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in), .clr_out(flag_clear_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in));
  // 200 MHz clock and a cycle ceiling against hangs
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected backup selection from config and comparator levels
  function automatic logic exp_bk(input logic [4:0] c, input logic t, input logic b);
    logic m;
    m = c[2:1] == 2'h0 ? t : c[2:1] == 2'h1 ? b : c[2:1] == 2'h2 ? t & b : t | b;
    return !c[4] && !m;
  endfunction : exp_bk
  // comparators move, then time for the two register stages
  task automatic supply(input logic t, input logic b);
    @(negedge clk_sys_in);
    {above_th_in, above_bat_in} = {t, b};
    repeat (4) @(negedge clk_sys_in);
  endtask : supply
  task automatic pulse(input logic t, output int k);
    @(negedge clk_sys_in);
    above_th_in = t;
    k = 0;
    repeat (3 * T) begin
      @(negedge clk_sys_in);
      k += (first_irq_pin_oe_out === 1'h1);
    end
  endtask : pulse
  initial begin
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in) sys_rst_in = 0;
    u_host.rd(8'h26, d);
    chk(d, bsc_pkg::BSC_CFG_RESET);
    u_host.wr(8'h26, 8'hff);
    u_host.rd(8'h26, d);
    chk(d, 8'h1f);
    chk({changeover_refresh_rate_out, changeover_compare_mode_out, changeover_threshold_select_out}, 8'h0f);
    u_host.rd(8'h27, d);
    chk(d, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      supply(1, 1);
      {ts_out_en_in, ts_out_in, ts_din_in, bus_scl_in, bus_sda_in, clk_out_sel_in} = seed[13:8];
      u_host.wr(8'h26, {seed[7:3], i[1:0], seed[0]});
      u_host.rd(8'h26, d);
      chk(d, {3'h0, seed[4:3], i[1:0], seed[0]});
      supply(seed[16], seed[17]);
      chk(on_backup_out, exp_bk({seed[4:3], i[1:0], seed[0]}, seed[16], seed[17]));
      chk(flag_valid_out, !on_backup_out);
      if (on_backup_out === 1'h1) chk({ts_din_out, clk_pin_oe_out, ts_pin_oe_out, second_irq_pin_oe_out, bus_scl_out, bus_sda_out, ts_mech_en_out}, 8'h07);
      else chk({ts_pin_out, ts_din_out, clk_pin_oe_out, ts_pin_oe_out, second_irq_pin_oe_out, bus_scl_out, bus_sda_out}, {1'h0, ts_out_in, ts_din_in, clk_out_sel_in, ts_out_en_in, 1'h1, bus_scl_in, bus_sda_in});
    end
    $display("test selection done");
    supply(1, 1);
    u_host.wr(8'h26, 8'h00);
    u_host.clear();
    supply(1, 1);
    chk(supply_changeover_flag_out, 0);
    supply(0, 1);
    chk(supply_changeover_flag_out, 0);
    supply(1, 1);
    chk({supply_changeover_flag_out, second_irq_pin_out}, 8'h02);
    repeat (20) @(negedge clk_sys_in);
    chk(supply_changeover_flag_out, 1);
    u_host.clear();
    supply(1, 1);
    chk({supply_changeover_flag_out, second_irq_pin_out}, 8'h01);
    irq_pulse_mode_in = 1;
    pulse(0, n);
    chk(n >= T && n <= 2 * T + 2, 1);
    pulse(1, n);
    chk(n >= T && n <= 2 * T + 2, 1);
    first_irq_pin_mode_in = bsc_pkg::BSC_PM_BATIND;
    irq_en_first_in = 0;
    supply(0, 1);
    chk(first_irq_pin_oe_out, 1);
    supply(1, 1);
    chk(first_irq_pin_oe_out, 0);
    $display("test flag and pins done");
    conclude();
  end
endmodule : tb_battery_switchover_control
